// File: flip_pkg.sv
// Shared constants and types for the four-level interrupt poller
package flip_pkg;
  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned NUM_LVL = 4;
  localparam logic [7:0] ADDR_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam int unsigned BIT_GLOBAL_EN = 7;
  // Bits 6 of the enable register and 7:6 of both priority registers are not implemented
  localparam logic [7:0] MASK_ENABLE = 8'hbf;
  localparam logic [7:0] MASK_PRIO = 8'h3f;
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  localparam int unsigned SRC_SERIAL = 4;
  localparam int unsigned SRC_TMR2 = 5;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam logic [1:0] LVL_TOP = 2'h3;

  // Register write port of the core's special function register bus
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flip_sfr_wr_t;

  // Per-cycle instruction status from the core's sequencer
  typedef struct packed {
    logic last_cycle;
    logic is_return_from_interrupt;
    logic touches_irq_regs;
  } flip_core_stat_t;

  // Hardware call request toward the core
  typedef struct packed {
    logic req;
    logic [2:0] src;
    logic [1:0] level;
  } flip_call_t;
endpackage

// File: flip_arbiter.sv
// Combinational winner selection among enabled sampled requests
`timescale 1ns/10ps
module flip_arbiter #(
  parameter int unsigned NSRC = flip_pkg::NUM_SRC
) (
  input wire logic [NSRC-1:0] pending,
  input wire logic [NSRC-1:0] prio_high,
  input wire logic [NSRC-1:0] prio_low,
  output logic found,
  output logic [2:0] win_src,
  output logic [1:0] win_level
);
  initial
  begin
    if (NSRC < 1 || NSRC > 7)
      $error("flip_arbiter: NSRC must be 1..7");
  end

  always_comb
  begin
    found = 1'b0;
    win_src = flip_pkg::SRC_NONE;
    win_level = 2'h0;
    // Walk from last to first so that a lower index wins ties
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pending[i] && (!found || {prio_high[i], prio_low[i]} >= win_level))
      begin
        found = 1'b1;
        win_src = 3'(i);
        win_level = {prio_high[i], prio_low[i]};
      end
    end
  end
endmodule

// File: flip_poller.sv
// Four-level interrupt poller: sampling, enables, priority and call issue
// Behaviour
// - Request flags are captured at the S5P2 phase and only those captures are polled one clock later, at the cycle enable of the same machine cycle.
// - A captured, enabled, unblocked request raises a hardware call request naming its source.
// - No call is raised while a routine of equal or higher level than the winner is in progress.
// - A call is raised only when polling coincides with the last cycle of the current instruction, which the core flags.
// - A return from interrupt or an access to the enable or priority registers blocks the call for that instruction.
// - A blocked request is not remembered; each poll looks only at fresh samples.
// - The fixed order only breaks ties within one level, and timer 2 is sixth and lowest.
// - The high priority register holds timer 2, serial, timer 1, ext 1, timer 0, ext 0 at bits 5 down to 0.
// - Same-level ties resolve ext 0, timer 0, ext 1, timer 1, serial, timer 2.
// - Each source has its own enable and a global enable suppresses all sources.
// - Level is the high bit over the low bit, 00 lowest through 11 highest.
// - Only a strictly higher level preempts, and a level 3 routine is never preempted.
`timescale 1ns/10ps
module flip_poller #(
  parameter int unsigned NSRC = flip_pkg::NUM_SRC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic s5p2_en,
  input wire logic cycle_en,
  input wire logic [NSRC-1:0] req_flags,
  input wire flip_pkg::flip_sfr_wr_t sfr_wr,
  input wire logic [7:0] sfr_raddr,
  input wire flip_pkg::flip_core_stat_t core_stat,
  output flip_pkg::flip_call_t call_out,
  output logic [7:0] sfr_rdata,
  output logic [flip_pkg::NUM_LVL-1:0] in_progress
);
  initial
  begin
    if (NSRC != flip_pkg::NUM_SRC)
      $error("flip_poller: register layout serves exactly six sources");
  end

  logic [7:0] enable_reg;
  logic [7:0] prio_high_reg;
  logic [7:0] prio_low_reg;
  logic [NSRC-1:0] sample_reg;
  logic [flip_pkg::NUM_LVL-1:0] active_reg;
  logic [flip_pkg::NUM_LVL-1:0] active_next;
  flip_pkg::flip_call_t call_reg;
  logic [7:0] rdata_reg;
  logic [NSRC-1:0] pending;
  logic found;
  logic [2:0] win_src;
  logic [1:0] win_level;
  logic [1:0] top_active;
  logic any_active;
  logic level_ok;
  logic blocked;

  // Register writes; unimplemented bits are held at zero regardless of what software writes
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      enable_reg <= flip_pkg::RST_ENABLE;
      prio_high_reg <= flip_pkg::RST_PRIO;
      prio_low_reg <= flip_pkg::RST_PRIO;
    end
    else if (sfr_wr.wr_en)
    begin
      if (sfr_wr.addr == flip_pkg::ADDR_ENABLE)
        enable_reg <= sfr_wr.wdata & flip_pkg::MASK_ENABLE;
      if (sfr_wr.addr == flip_pkg::ADDR_PRIO_HIGH)
        prio_high_reg <= sfr_wr.wdata & flip_pkg::MASK_PRIO;
      if (sfr_wr.addr == flip_pkg::ADDR_PRIO_LOW)
        prio_low_reg <= sfr_wr.wdata & flip_pkg::MASK_PRIO;
    end
  end

  // Read mux is registered so the data output comes from a flop
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rdata_reg <= 8'h00;
    else
    begin
      unique case (sfr_raddr)
        flip_pkg::ADDR_ENABLE: rdata_reg <= enable_reg;
        flip_pkg::ADDR_PRIO_HIGH: rdata_reg <= prio_high_reg;
        flip_pkg::ADDR_PRIO_LOW: rdata_reg <= prio_low_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  // Samples are overwritten every machine cycle, so nothing blocked is carried forward
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      sample_reg <= '0;
    else if (s5p2_en)
      sample_reg <= req_flags;
  end

  assign pending = sample_reg & enable_reg[NSRC-1:0] & {NSRC{enable_reg[flip_pkg::BIT_GLOBAL_EN]}};

  flip_arbiter #(
    .NSRC(NSRC)
  ) u_arb (
    .pending(pending),
    .prio_high(prio_high_reg[NSRC-1:0]),
    .prio_low(prio_low_reg[NSRC-1:0]),
    .found(found),
    .win_src(win_src),
    .win_level(win_level)
  );

  always_comb
  begin
    any_active = |active_reg;
    top_active = 2'h0;
    for (int l = 0; l < flip_pkg::NUM_LVL; l++)
    begin
      if (active_reg[l])
        top_active = 2'(l);
    end
    // Level 3 can never exceed an active level 3, so it is never preempted
    level_ok = !any_active || (win_level > top_active);
    blocked = !level_ok || !core_stat.last_cycle
      || core_stat.is_return_from_interrupt || core_stat.touches_irq_regs;
  end

  // Call request stands for one machine-cycle enable period
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      call_reg <= '{req: 1'b0, src: flip_pkg::SRC_NONE, level: 2'h0};
    else if (cycle_en)
    begin
      call_reg.req <= found && !blocked;
      call_reg.src <= found ? win_src : flip_pkg::SRC_NONE;
      call_reg.level <= win_level;
    end
  end

  always_comb
  begin
    active_next = active_reg;
    // Only the final cycle of a return counts, so a multi-cycle return clears one marker, not several
    if (cycle_en && core_stat.is_return_from_interrupt && core_stat.last_cycle && any_active)
      active_next[top_active] = 1'b0;
    if (cycle_en && found && !blocked)
      active_next[win_level] = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      active_reg <= '0;
    else
      active_reg <= active_next;
  end

  assign call_out = call_reg;
  assign sfr_rdata = rdata_reg;
  assign in_progress = active_reg;
endmodule

// File: flip_checker.sv
// Assertion checker for the interrupt poller
`timescale 1ns/10ps
module flip_checker #(
  parameter int unsigned NSRC = 6
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic s5p2_en,
  input wire logic cycle_en,
  input wire logic [NSRC-1:0] req_flags,
  input wire flip_pkg::flip_sfr_wr_t sfr_wr,
  input wire logic [7:0] sfr_raddr,
  input wire flip_pkg::flip_core_stat_t core_stat,
  input wire flip_pkg::flip_call_t call_out,
  input wire logic [7:0] sfr_rdata,
  input wire logic [3:0] in_progress
);
  logic [NSRC-1:0] smp_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk)
    smp_reg <= !nrst ? '0 : s5p2_en ? req_flags : smp_reg;
  a_flag_sampled: assert property ($rose(call_out.req) |-> smp_reg[call_out.src])
    else $error("call without captured flag");
  a_req_stands: assert property (call_out.req && !cycle_en |=> call_out.req)
    else $error("call dropped early");
  a_level_above: assert property ($rose(call_out.req) |-> ($past(in_progress) >> call_out.level) == 4'h0)
    else $error("call over busy level");
  a_last_cycle: assert property ($rose(call_out.req) |-> $past(cycle_en && core_stat.last_cycle))
    else $error("call mid instruction");
  a_return_from_interrupt_blocks: assert property (cycle_en && core_stat[1:0] != 2'h0 |=> !call_out.req)
    else $error("call after return or access");
  a_top_kept: assert property (cycle_en && in_progress[3] |=> !call_out.req)
    else $error("top level preempted");
  a_marker_set: assert property ($rose(call_out.req) |-> in_progress[call_out.level])
    else $error("marker not set");
  a_prio_bits: assert property (sfr_raddr == 8'hb7 |=> sfr_rdata[7:6] == 2'h0)
    else $error("reserved bits read high");
  c_call: cover property ($rose(call_out.req));
  c_top: cover property (in_progress[3]);
  c_return_from_interrupt: cover property (cycle_en && core_stat.is_return_from_interrupt);
endmodule
bind flip_poller flip_checker #(.NSRC(NSRC)) u_chk (.*);

// File: flip_core_model.sv
// Core sequencer model: phase pulses and instruction status
`timescale 1ns/10ps
module flip_core_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] stat_cmd,
  output logic s5p2_en,
  output logic cycle_en,
  output flip_pkg::flip_core_stat_t core_stat
);
  logic [1:0] ph_reg;
  // Four clocks a machine cycle keeps runs short
  always_ff @(posedge mclk)
    ph_reg <= nrst ? ph_reg + 2'h1 : 2'h0;
  assign s5p2_en = ph_reg == 2'h2;
  assign cycle_en = ph_reg == 2'h3;
  assign core_stat = stat_cmd;
endmodule

// File: four_level_interrupt_poller_tb.sv
// Bench for the interrupt poller
`timescale 1ns/10ps
module four_level_interrupt_poller_tb;
  logic mclk = 1'b0, nrst = 1'b0, s5p2_en, cycle_en;
  logic [5:0] req_flags = 6'h00;
  logic [2:0] stat_cmd = 3'h4;
  logic [7:0] sfr_raddr = 8'h00, sfr_rdata;
  logic [3:0] in_progress;
  flip_pkg::flip_sfr_wr_t sfr_wr = '0;
  flip_pkg::flip_core_stat_t core_stat;
  flip_pkg::flip_call_t call_out;
  int n_fail = 0, num_checks = 0;
  always #12.5 mclk = ~mclk;
  flip_core_model u_core (.*);
  flip_poller u_dut (.*);
  task stop_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [9:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, d, e);
    @(posedge mclk) sfr_wr <= {w, a, d};
    @(posedge mclk) sfr_wr <= '0;
    sfr_raddr <= a;
    @(posedge mclk) #1 chk({2'h0, sfr_rdata}, {2'h0, e});
  endtask
  // Blocked polls compare the request bit and in_progress, with source and level masked
  // The enable is looked at mid-cycle where it has settled, then the poll edge follows
  task poll(input logic [5:0] f, c, input logic [2:0] st, input logic [3:0] ip);
    do @(negedge mclk); while (cycle_en !== 1'b1);
    @(posedge mclk);
    req_flags <= f;
    stat_cmd <= st;
    do @(negedge mclk); while (cycle_en !== 1'b1);
    @(posedge mclk);
    req_flags <= 6'h00;
    stat_cmd <= 3'h4;
    #1 chk({call_out & {6{call_out.req}}, in_progress}, {c, ip});
  endtask
  task t_regs;
    acc(1'b0, 8'hb8, 8'h00, 8'h00);
    acc(1'b1, 8'hb7, 8'h3f, 8'h3f);
    acc(1'b1, 8'ha8, 8'h7f, 8'h3f);
    acc(1'b1, 8'h5a, 8'hff, 8'h00);
  endtask
  task t_en;
    poll(6'h3f, 6'h00, 3'h4, 4'h0);
    acc(1'b1, 8'hb7, 8'h00, 8'h00);
    acc(1'b1, 8'ha8, 8'hbd, 8'hbd);
    poll(6'h02, 6'h00, 3'h4, 4'h0);
    poll(6'h3e, 6'h28, 3'h4, 4'h1);
  endtask
  task t_lvl;
    acc(1'b1, 8'hb7, 8'h20, 8'h20);
    acc(1'b1, 8'hb8, 8'h30, 8'h30);
    poll(6'h3f, 6'h37, 3'h4, 4'h9);
    poll(6'h3f, 6'h00, 3'h4, 4'h9);
    poll(6'h3f, 6'h00, 3'h6, 4'h1);
    poll(6'h3f, 6'h00, 3'h0, 4'h1);
    poll(6'h00, 6'h00, 3'h4, 4'h1);
    poll(6'h3f, 6'h00, 3'h5, 4'h1);
    poll(6'h11, 6'h31, 3'h4, 4'h3);
    poll(6'h01, 6'h00, 3'h4, 4'h3);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_en();
    t_lvl();
    stop_test();
  end
  initial
  begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule
